// file: logic/fsrs_status_top.sv
module fsrs_status_top (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       chip_select_n,
   input  wire logic       serial_clock,
   input  wire logic       data_line_zero,
   input  wire logic       write_protect_n,
   input  wire logic       hold_n,
   output logic            data_line_one_out,
   output logic            data_line_one_oe,
   output logic            write_in_progress,
   output logic            write_enable_latch,
   output logic [3:0]      block_protect,
   output logic            protect_bottom,
   output logic            quad_io_enable,
   output logic            powered_down,
   output logic            internal_reset
);
   // raw pin order: hold, wp, si, sclk, cs
   logic [4:0]                  pin_meta;
   logic [4:0]                  pin_sync;
   logic                        sclk_q;
   logic                        cs_q;
   logic [7:0]                  sr1;
   logic [7:0]                  sr2;
   logic [7:0]                  sr3;
   logic [7:0]                  ear;
   logic [fsrs_pkg::BUSY_W-1:0] busy_cnt;
   logic [2:0]                  bit_cnt;
   logic [6:0]                  shreg;
   logic [7:0]                  out_sh;
   logic [1:0]                  byte_idx;
   logic [7:0]                  op;
   logic [23:0]                 addr;
   logic [7:0]                  wbuf1;
   logic [7:0]                  wbuf2;
   logic                        seen_edge;
   fsrs_pkg::fsrs_state_t       state;
   fsrs_pkg::fsrs_state_t       next_state;

   fsrs_link_if link ();

   fsrs_reset_detect u_detect (
      .clk  (clk),
      .srst (srst),
      .link (link)
   );

   function automatic logic protected_at(input logic [3:0] bp, input logic tb,
                                         input logic [fsrs_pkg::ADDR_W-1:0] a);
      logic [fsrs_pkg::ADDR_W-1:0] size;
      logic [fsrs_pkg::ADDR_W-1:0] top_base;
      size     = '0;
      top_base = '0;
      if (bp != 4'h0) begin
         size = fsrs_pkg::ADDR_W'(1) << (fsrs_pkg::AREA_LSB + int'(bp) - 1);
      end
      top_base = fsrs_pkg::ADDR_W'(0) - size;
      if (bp == 4'h0) begin
         protected_at = 1'b0;
      end else if (int'(bp) + fsrs_pkg::AREA_LSB > fsrs_pkg::ADDR_W) begin
         protected_at = 1'b1;
      end else begin
         protected_at = tb ? (a < size) : (a >= top_base);
      end
   endfunction : protected_at

   always_ff @(posedge clk) begin
      pin_meta <= {hold_n, write_protect_n, data_line_zero, serial_clock, chip_select_n};
      pin_sync <= pin_meta;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else begin
         sclk_q <= pin_sync[1];
         cs_q   <= pin_sync[0];
      end
   end

   wire cs_s        = pin_sync[0];
   wire sclk_s      = pin_sync[1];
   wire si_s        = pin_sync[2];
   wire selected    = ~cs_s;
   wire quad_on     = sr2[fsrs_pkg::QUAD_BIT];
   // pins lose control role in quad mode
   wire wp_eff_n    = quad_on | pin_sync[3];
   wire hold_act    = ~quad_on & ~pin_sync[4];
   wire cs_fall     = ~cs_s & cs_q;
   wire cs_rise     = cs_s & ~cs_q;
   wire sclk_any    = selected & (sclk_s ^ sclk_q);
   wire sclk_rise   = selected & sclk_s & ~sclk_q & ~hold_act & ~powered_down;
   wire sclk_fall   = selected & ~sclk_s & sclk_q & ~hold_act & ~powered_down;
   wire byte_done   = sclk_rise & (bit_cnt == 3'h7);
   wire [7:0] byte_val = {shreg, si_s};
   wire sr_busy     = sr1[fsrs_pkg::BUSY_BIT];
   wire sr_latch    = sr1[fsrs_pkg::LATCH_BIT];
   wire hw_locked   = sr1[fsrs_pkg::LOCKSEL_BIT] & ~wp_eff_n;
   wire rst_int     = link.reset_fire;
   wire [fsrs_pkg::ADDR_W-1:0] full_addr = {ear[fsrs_pkg::EA_ADDR_W-1:0], addr};
   wire addr_prot   = protected_at(sr1[fsrs_pkg::BP_LSB +: 4], sr1[fsrs_pkg::TB_BIT], full_addr);
   wire addr_full   = (byte_idx == 2'h3);
   wire pe_commit   = cs_rise & (state == fsrs_pkg::ST_ADDR) & addr_full & sr_latch & ~sr_busy & ~addr_prot;
   wire wstat_ok    = (op == fsrs_pkg::OP_WSTAT) & ~hw_locked;
   wire wear_ok     = (op == fsrs_pkg::OP_WEAR);
   // status writes need latch, not locked
   wire wr_commit   = cs_rise & (state == fsrs_pkg::ST_WDATA) & (byte_idx != 2'h0) & sr_latch & ~sr_busy &
                      (wstat_ok | wear_ok);
   wire start_busy  = pe_commit | (wr_commit & wstat_ok);
   wire cmd_byte    = byte_done & (state == fsrs_pkg::ST_CMD);
   wire [7:0] rd_val = (op == fsrs_pkg::OP_RDSR2) ? sr2 :
                       (op == fsrs_pkg::OP_RDSR3) ? sr3 :
                       (op == fsrs_pkg::OP_RDEAR) ? ear : sr1;

   assign link.cs_fall   = cs_fall;
   assign link.cs_rise   = cs_rise;
   assign link.si_level  = si_s;
   assign link.sclk_edge = sclk_any;

   always_comb begin
      next_state = state;
      if (cs_fall || cs_rise) begin
         next_state = fsrs_pkg::ST_CMD;
      end else if (byte_done) begin
         case (state)
            fsrs_pkg::ST_CMD: begin
               case (byte_val)
                  fsrs_pkg::OP_RDSR1, fsrs_pkg::OP_RDSR2,
                  fsrs_pkg::OP_RDSR3, fsrs_pkg::OP_RDEAR: next_state = fsrs_pkg::ST_READ;
                  fsrs_pkg::OP_WSTAT, fsrs_pkg::OP_WEAR:  next_state = fsrs_pkg::ST_WDATA;
                  fsrs_pkg::OP_PROG, fsrs_pkg::OP_SECT,
                  fsrs_pkg::OP_BLK:                       next_state = fsrs_pkg::ST_ADDR;
                  default:                                next_state = fsrs_pkg::ST_SKIP;
               endcase
            end
            fsrs_pkg::ST_ADDR:  next_state = fsrs_pkg::ST_ADDR;
            fsrs_pkg::ST_WDATA: next_state = fsrs_pkg::ST_WDATA;
            fsrs_pkg::ST_READ:  next_state = fsrs_pkg::ST_READ;
            default:            next_state = fsrs_pkg::ST_SKIP;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst || rst_int || cs_fall) begin
         bit_cnt <= 3'h0;
         shreg   <= 7'h00;
      end else if (sclk_rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         shreg   <= byte_val[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst || rst_int) begin
         state    <= fsrs_pkg::ST_CMD;
         op       <= 8'h00;
         byte_idx <= 2'h0;
      end else begin
         state <= next_state;
         if (cs_fall) begin
            byte_idx <= 2'h0;
         end else if (cmd_byte) begin
            op <= byte_val;
         end else if (byte_done && !addr_full) begin
            byte_idx <= byte_idx + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         addr  <= 24'h000000;
         wbuf1 <= 8'h00;
         wbuf2 <= 8'h00;
      end else if (byte_done && !addr_full) begin
         if (state == fsrs_pkg::ST_ADDR) begin
            addr <= {addr[15:0], byte_val};
         end
         if (state == fsrs_pkg::ST_WDATA && byte_idx == 2'h0) begin
            wbuf1 <= byte_val;
         end
         if (state == fsrs_pkg::ST_WDATA && byte_idx == 2'h1) begin
            wbuf2 <= byte_val;
         end
      end
   end

   // non-volatile bits survive the signalled reset
   always_ff @(posedge clk) begin
      if (srst) begin
         sr1 <= fsrs_pkg::SR1_RST;
         sr2 <= fsrs_pkg::SR2_RST;
         sr3 <= fsrs_pkg::SR3_RST;
         ear <= fsrs_pkg::EAR_RST;
      end else if (rst_int) begin
         sr1[fsrs_pkg::BUSY_BIT]  <= 1'b0;
         sr1[fsrs_pkg::LATCH_BIT] <= 1'b0;
         ear <= fsrs_pkg::EAR_RST;
      end else begin
         if (start_busy) begin
            sr1[fsrs_pkg::BUSY_BIT] <= 1'b1;
         end else if (busy_cnt == fsrs_pkg::BUSY_W'(1)) begin
            sr1[fsrs_pkg::BUSY_BIT] <= 1'b0;
         end
         if (pe_commit || wr_commit) begin
            sr1[fsrs_pkg::LATCH_BIT] <= 1'b0;
         end else if (cmd_byte && !sr_busy && byte_val == fsrs_pkg::OP_WREN) begin
            sr1[fsrs_pkg::LATCH_BIT] <= 1'b1;
         end else if (cmd_byte && !sr_busy && byte_val == fsrs_pkg::OP_WRDI) begin
            sr1[fsrs_pkg::LATCH_BIT] <= 1'b0;
         end
         // protect fields by status write only
         if (wr_commit && wstat_ok) begin
            sr1[7:2] <= wbuf1[7:2] & fsrs_pkg::SR1_WMASK[7:2];
            if (byte_idx == 2'h2) begin
               sr2 <= (sr2 & ~fsrs_pkg::SR2_WMASK) | (wbuf2 & fsrs_pkg::SR2_WMASK);
            end
         end
         if (wr_commit && wear_ok) begin
            ear <= wbuf1 & fsrs_pkg::EAR_WMASK;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || rst_int) begin
         busy_cnt <= '0;
      end else if (start_busy) begin
         busy_cnt <= fsrs_pkg::BUSY_W'(fsrs_pkg::BUSY_CYC);
      end else if (busy_cnt != '0) begin
         busy_cnt <= busy_cnt - fsrs_pkg::BUSY_W'(1);
      end
   end

   // drive only after a clock edge in this frame
   always_ff @(posedge clk) begin
      if (srst || rst_int || cs_s) begin
         seen_edge <= 1'b0;
      end else if (sclk_any) begin
         seen_edge <= 1'b1;
      end else if (cs_fall) begin
         seen_edge <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || rst_int || cs_s) begin
         out_sh            <= 8'h00;
         data_line_one_out <= 1'b0;
         data_line_one_oe  <= 1'b0;
      end else if (byte_done && next_state == fsrs_pkg::ST_READ) begin
         out_sh <= (state == fsrs_pkg::ST_CMD) ? ((byte_val == fsrs_pkg::OP_RDSR2) ? sr2 :
                   (byte_val == fsrs_pkg::OP_RDSR3) ? sr3 :
                   (byte_val == fsrs_pkg::OP_RDEAR) ? ear : sr1) : rd_val;
      end else if (sclk_fall && state == fsrs_pkg::ST_READ && (seen_edge || sclk_any)) begin
         data_line_one_out <= out_sh[7];
         data_line_one_oe  <= 1'b1;
         out_sh            <= {out_sh[6:0], out_sh[7]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst || rst_int) begin
         powered_down <= 1'b0;
      end else if (cs_fall) begin
         powered_down <= 1'b0;
      end else if (cs_rise && state == fsrs_pkg::ST_SKIP && op == fsrs_pkg::OP_DPD && !sr_busy) begin
         powered_down <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         write_in_progress  <= 1'b0;
         write_enable_latch <= 1'b0;
         block_protect      <= 4'h0;
         protect_bottom     <= 1'b0;
         quad_io_enable     <= 1'b0;
         internal_reset     <= 1'b0;
      end else begin
         write_in_progress  <= sr_busy;
         write_enable_latch <= sr_latch;
         block_protect      <= sr1[fsrs_pkg::BP_LSB +: 4];
         protect_bottom     <= sr1[fsrs_pkg::TB_BIT];
         quad_io_enable     <= quad_on;
         internal_reset     <= rst_int;
      end
   end
endmodule : fsrs_status_top

// file: logic/fsrs_pkg.sv
// Overview of operation
// - The data input level is captured when chip select rises at the end of each request pulse.
// - The four captured levels must read low, high, low, high over consecutive pulses.
// - After the fourth good pulse completes, the internal reset is started.
// - The output data line stays undriven after chip select falls until the first serial clock edge.
// - A falling chip select wakes the device from power-down.
// - Status bit 0 reads 1 while a program, erase or status write runs, else 0.
// - Status bit 1 shows the write enable latch; while it is clear, status writes, programs and erases are refused.
// - Block protect bits 5 to 2 choose the area that refuses program, sector erase and block erase.
// - Block protect bits change only by the status write command and not while hardware protected.
// - The top/bottom bit 6 resets to 0 for a top area; 1 moves the area to the bottom.
// - The top/bottom bit changes only by the status write command.
// - Bit 7 selects software or hardware write protection of the status register.
// - With bit 7 set and the write protect pin low, all status writes are locked; else they need the latch.
// - With quad enable clear the write protect and hold pins keep their function; set, they are data lines.
package fsrs_pkg;
   localparam int   CLK_NS       = 10;
   // program and erase duration, shortened model of the array
   localparam int   BUSY_NS      = 2000;
   localparam int   BUSY_CYC     = (BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int   BUSY_W       = 16;

   localparam int   BUSY_BIT     = 0;
   localparam int   LATCH_BIT    = 1;
   localparam int   BP_LSB       = 2;
   localparam int   TB_BIT       = 6;
   localparam int   LOCKSEL_BIT  = 7;
   localparam int   QUAD_BIT     = 1;
   localparam int   WPS_BIT      = 6;
   localparam int   EA_ADDR_W    = 3;
   localparam int   EA_DLP_BIT   = 3;

   localparam logic [7:0] SR1_RST = 8'h00;
   localparam logic [7:0] SR2_RST = 8'h00;
   localparam logic [7:0] SR3_RST = 8'h40;
   localparam logic [7:0] EAR_RST = 8'h00;
   localparam logic [7:0] SR1_WMASK = 8'hFC;
   localparam logic [7:0] SR2_WMASK = 8'h42;
   localparam logic [7:0] EAR_WMASK = 8'h0F;

   localparam int   ADDR_W       = 27;
   localparam int   AREA_LSB     = 16;

   localparam logic [7:0] OP_WREN  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_RDSR3 = 8'h15;
   localparam logic [7:0] OP_RDEAR = 8'hC8;
   localparam logic [7:0] OP_WSTAT = 8'h01;
   localparam logic [7:0] OP_WEAR  = 8'hC5;
   localparam logic [7:0] OP_PROG  = 8'h02;
   localparam logic [7:0] OP_SECT  = 8'h20;
   localparam logic [7:0] OP_BLK   = 8'hD8;
   localparam logic [7:0] OP_DPD   = 8'hB9;

   typedef enum logic [2:0] {
      ST_CMD   = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WDATA = 3'b010,
      ST_READ  = 3'b011,
      ST_SKIP  = 3'b100
   } fsrs_state_t;
endpackage : fsrs_pkg

// file: logic/fsrs_link_if.sv
interface fsrs_link_if;
   logic cs_fall;
   logic cs_rise;
   logic si_level;
   logic sclk_edge;
   logic reset_fire;

   modport top (output cs_fall, output cs_rise, output si_level, output sclk_edge, input reset_fire);
   modport det (input cs_fall, input cs_rise, input si_level, input sclk_edge, output reset_fire);
endinterface : fsrs_link_if

// file: logic/fsrs_reset_detect.sv
module fsrs_reset_detect (
   input  wire logic  clk,
   input  wire logic  srst,
   fsrs_link_if.det   link
);
   logic [1:0] pulse_cnt;
   logic       spoiled;
   logic       fire;

   wire spoil_now  = link.sclk_edge;
   wire level_ok   = (link.si_level == pulse_cnt[0]) & ~spoiled & ~spoil_now;
   // a fresh low may open a new sequence
   wire restart_one = ~link.si_level & ~spoiled & ~spoil_now;

   always_ff @(posedge clk) begin
      if (srst) begin
         spoiled <= 1'b0;
      // an edge in the select cycle still spoils the pulse
      end else if (spoil_now) begin
         spoiled <= 1'b1;
      end else if (link.cs_fall) begin
         spoiled <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pulse_cnt <= 2'h0;
         fire      <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (link.cs_rise) begin
            if (level_ok) begin
               pulse_cnt <= pulse_cnt + 2'h1;
               fire      <= (pulse_cnt == 2'h3);
            end else begin
               pulse_cnt <= restart_one ? 2'h1 : 2'h0;
            end
         end
      end
   end

   assign link.reset_fire = fire;
endmodule : fsrs_reset_detect

// file: test/fsrs_host_model.sv
module fsrs_host_model (
   input  wire logic clk,
   input  wire logic data_line_one_out,
   input  wire logic data_line_one_oe,
   output logic      chip_select_n,
   output logic      serial_clock,
   output logic      data_line_zero
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      data_line_zero = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // mode 0, msb first; low phase 16 clk, high 8
   task automatic spi(input logic [7:0] op, input int nb, input logic [23:0] d, output logic [7:0] rd);
      logic [31:0] bits;
      bits = {op, d};
      rd = 8'h00;
      @(posedge clk) chip_select_n <= 1'b0;
      for (int i = 0; i < 8 + 8 * nb; i++) begin
         tick(8);
         data_line_zero <= bits[31-i];
         tick(8);
         serial_clock <= 1'b1;
         // undriven line must not pass for a stale bit
         rd = {rd[6:0], data_line_one_oe ? data_line_one_out : ~rd[0]};
         tick(8);
         serial_clock <= 1'b0;
      end
      tick(8);
      chip_select_n <= 1'b1;
      tick(8);
      data_line_zero <= ~data_line_zero;
      tick(8);
   endtask : spi
   // level set with select fall, clock pulsed once if wiggle is set
   task automatic pulse(input logic lvl, input logic wiggle);
      @(posedge clk) begin
         chip_select_n <= 1'b0;
         data_line_zero <= lvl;
      end
      tick(8);
      serial_clock <= wiggle;
      tick(8);
      serial_clock <= 1'b0;
      tick(8);
      chip_select_n <= 1'b1;
      tick(12);
   endtask : pulse
endmodule : fsrs_host_model

// file: test/fsrs_status_props.sv
module fsrs_status_props (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       chip_select_n,
   input wire logic       serial_clock,
   input wire logic       data_line_zero,
   input wire logic       write_protect_n,
   input wire logic       hold_n,
   input wire logic       data_line_one_out,
   input wire logic       data_line_one_oe,
   input wire logic       write_in_progress,
   input wire logic       write_enable_latch,
   input wire logic [3:0] block_protect,
   input wire logic       protect_bottom,
   input wire logic       quad_io_enable,
   input wire logic       powered_down,
   input wire logic       internal_reset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // clock edge seen since select fell, at the pin
   logic moved;
   logic sclk_q;
   always_ff @(posedge clk) begin
      sclk_q <= serial_clock;
      moved <= !srst && !chip_select_n && (moved || serial_clock != sclk_q);
   end
   property p_oe_idle; !moved [*6] |-> !data_line_one_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("output driven before a clock edge");
   property p_busy_min; $rose(write_in_progress) |-> ##195 write_in_progress; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy ended early");
   property p_busy_max; $rose(write_in_progress) |-> ##[196:205] !write_in_progress; endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy ended late");
   property p_latch_clr; $rose(write_in_progress) |-> ##[0:2] !write_enable_latch; endproperty
   a_latch_clr: assert property (p_latch_clr) else $error("latch kept after commit");
   property p_busy_latch;
      $rose(write_in_progress) |-> $past(write_enable_latch) || $past(write_enable_latch, 2);
   endproperty
   a_busy_latch: assert property (p_busy_latch) else $error("busy without latch");
   property p_cfg_hold;
      !chip_select_n [*4] |-> $stable({block_protect, protect_bottom, quad_io_enable});
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed inside a frame");
   property p_rst_cs; internal_reset |-> chip_select_n && $past(chip_select_n, 3); endproperty
   a_rst_cs: assert property (p_rst_cs) else $error("reset without select high");
   property p_rst_clr;
      internal_reset |-> ##2 !(write_enable_latch || powered_down || write_in_progress);
   endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("state kept over reset");
   property p_wake; powered_down && $fell(chip_select_n) |-> ##[1:8] !powered_down; endproperty
   a_wake: assert property (p_wake) else $error("no wake on select");
   c_busy: cover property ($rose(write_in_progress));
   c_reset: cover property (internal_reset);
   c_wake: cover property (powered_down && $fell(chip_select_n));
endmodule : fsrs_status_props

bind fsrs_status_top fsrs_status_props chk_u (
   .clk(clk), .srst(srst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
   .data_line_zero(data_line_zero), .write_protect_n(write_protect_n), .hold_n(hold_n),
   .data_line_one_out(data_line_one_out), .data_line_one_oe(data_line_one_oe),
   .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
   .block_protect(block_protect), .protect_bottom(protect_bottom), .quad_io_enable(quad_io_enable),
   .powered_down(powered_down), .internal_reset(internal_reset)
);

// file: test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, srst, chip_select_n, serial_clock, data_line_zero, write_protect_n, hold_n;
   logic        data_line_one_out, data_line_one_oe, write_in_progress, write_enable_latch;
   logic        protect_bottom, quad_io_enable, powered_down, internal_reset;
   logic [3:0]  block_protect;
   logic [7:0]  rd;
   int          num_errors, tests_run, cycles, rst_seen;
   // status byte, opcode, address, busy expected
   logic [7:0]  sr_tab [4] = '{8'h3C, 8'h04, 8'h44, 8'h44};
   logic [7:0]  op_tab [4] = '{8'h02, 8'h20, 8'hD8, 8'h02};
   logic [23:0] ad_tab [4] = '{24'h000000, 24'h000000, 24'h000000, 24'h010000};
   logic        bz_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

   fsrs_status_top dut_u (
      .clk(clk), .srst(srst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
      .data_line_zero(data_line_zero), .write_protect_n(write_protect_n), .hold_n(hold_n),
      .data_line_one_out(data_line_one_out), .data_line_one_oe(data_line_one_oe),
      .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
      .block_protect(block_protect), .protect_bottom(protect_bottom), .quad_io_enable(quad_io_enable),
      .powered_down(powered_down), .internal_reset(internal_reset));
   fsrs_host_model host_u (
      .clk(clk), .data_line_one_out(data_line_one_out), .data_line_one_oe(data_line_one_oe),
      .chip_select_n(chip_select_n), .serial_clock(serial_clock), .data_line_zero(data_line_zero));

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (internal_reset === 1'b1) rst_seen <= rst_seen + 1;
      if (cycles == 40000) begin
         num_errors = num_errors + 1;
         summarize();
      end
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] d);
      host_u.spi(op, nb, d, rd);
   endtask : cmd
   task automatic reg_is(input logic [7:0] op, input logic [7:0] exp);
      host_u.spi(op, 1, 24'h000000, rd);
      check($sformatf("reg %h", op), exp, rd);
   endtask : reg_is
   task automatic wait_idle;
      for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++) @(posedge clk);
   endtask : wait_idle
   task automatic set_status(input logic [15:0] v, input int nb);
      cmd(8'h06, 0, 24'h000000);
      cmd(8'h01, nb, {v, 8'h00});
      wait_idle();
   endtask : set_status
   task automatic pulses(input logic [7:0] lv, input logic [7:0] wg, input int n);
      for (int i = 0; i < n; i++) host_u.pulse(lv[i], wg[i]);
   endtask : pulses

   initial begin
      clk = 1'b0;
      srst = 1'b1;
      write_protect_n = 1'b1;
      hold_n = 1'b1;
      num_errors = 0;
      tests_run = 0;
      cycles = 0;
      rst_seen = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      check("flags", 8'h00, {write_in_progress, write_enable_latch, block_protect,
                             protect_bottom, quad_io_enable});
      reg_is(8'h05, 8'h00);
      reg_is(8'h15, 8'h40);
      cmd(8'h01, 1, 24'h3C0000);
      check("refused", 8'h00, {write_in_progress, block_protect, 3'h0});
      cmd(8'h06, 0, 24'h000000);
      check("latch", 8'h01, {7'h00, write_enable_latch});
      reg_is(8'h05, 8'h02);
      cmd(8'h01, 1, 24'h3C0000);
      check("busy", 8'h01, {7'h00, write_in_progress});
      wait_idle();
      check("idle", 8'h3C, {2'h0, block_protect, write_enable_latch, write_in_progress});
      reg_is(8'h05, 8'h3C);
      for (int i = 0; i < 4; i++) begin
         set_status({sr_tab[i], 8'h00}, 1);
         cmd(8'h06, 0, 24'h000000);
         cmd(op_tab[i], 3, ad_tab[i]);
         check("area", {7'h00, bz_tab[i]}, {7'h00, write_in_progress});
         wait_idle();
      end
      check("bottom", 8'h01, {7'h00, protect_bottom});
      set_status(16'h8000, 1);
      write_protect_n <= 1'b0;
      cmd(8'h06, 0, 24'h000000);
      cmd(8'h01, 1, 24'h3C0000);
      check("locked", 8'h00, {write_in_progress, block_protect, protect_bottom, 2'h0});
      write_protect_n <= 1'b1;
      set_status(16'h8002, 2);
      check("quad", 8'h01, {7'h00, quad_io_enable});
      reg_is(8'h35, 8'h02);
      write_protect_n <= 1'b0;
      set_status(16'h0000, 2);
      reg_is(8'h05, 8'h00);
      check("quad off", 8'h00, {7'h00, quad_io_enable});
      write_protect_n <= 1'b1;
      cmd(8'h06, 0, 24'h000000);
      cmd(8'h04, 0, 24'h000000);
      check("disable", 8'h00, {7'h00, write_enable_latch});
      hold_n <= 1'b0;
      cmd(8'h06, 0, 24'h000000);
      check("hold", 8'h00, {7'h00, write_enable_latch});
      hold_n <= 1'b1;
      cmd(8'h06, 0, 24'h000000);
      cmd(8'hC5, 1, 24'h0F0000);
      reg_is(8'hC8, 8'h0F);
      cmd(8'h06, 0, 24'h000000);
      pulses(8'h16, 8'h00, 6);
      check("partial", 8'h80, {write_enable_latch, rst_seen[6:0]});
      pulses(8'h01, 8'h00, 1);
      check("reset", 8'h01, {write_enable_latch, rst_seen[6:0]});
      reg_is(8'hC8, 8'h00);
      pulses(8'hAA, 8'h08, 8);
      check("edge", 8'h02, {write_enable_latch, rst_seen[6:0]});
      cmd(8'hB9, 0, 24'h000000);
      check("asleep", 8'h01, {7'h00, powered_down});
      pulses(8'h00, 8'h00, 1);
      check("wake", 8'h00, {7'h00, powered_down});
      summarize();
   end
endmodule : testbench
